// ---- src/pew_pkg.sv ----
package pew_pkg;
    localparam int CLK_NS         = 4;
    localparam int PU_WRITE_MS    = 10;
    localparam int PU_WRITE_CYC   = PU_WRITE_MS * 1000000 / CLK_NS;
    localparam int PU_READ_US     = 1;
    localparam int PU_READ_CYC    = (PU_READ_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PAGE_WIN_US    = 100;
    localparam int PAGE_WIN_CYC   = PAGE_WIN_US * 1000 / CLK_NS;
    localparam int GLITCH_NS      = 10;
    localparam int GLITCH_CYC     = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS      = 90;
    localparam int SYNC_CYC       = 2;
    localparam int ACCESS_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int WE_NS          = 100;
    localparam int WE_CYC         = (WE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NS       = 10;
    localparam int SETUP_CYC      = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_NS        = 10;
    localparam int HOLD_CYC       = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_LAT_CYC     = SETUP_CYC + WE_CYC + HOLD_CYC + 5;
    localparam int PAGE_BYTES     = 64;
    localparam int PAGE_MSB       = 10;
    localparam int PAGE_LSB       = 6;
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CMD_READ_BIT   = 0;
    localparam int CMD_WRITE_BIT  = 1;
    localparam int CMD_POLL_BIT   = 2;
    localparam int ST_BUSY        = 0;
    localparam int ST_PAGE_OPEN   = 1;
    localparam int ST_ERR         = 2;
    localparam int ST_WR_OK       = 3;
    localparam int ST_RD_OK       = 4;
    localparam int ST_DONE        = 5;
    localparam int ST_RDY         = 6;
    localparam int ST_DQ5         = 7;
    localparam int ST_PROG        = 8;
    localparam int ST_POLL        = 9;

    typedef enum logic [2:0] {
        PH_IDLE, PH_RD_SETUP, PH_RD_WAIT, PH_RD_END, PH_WR_SETUP, PH_WR_PULSE, PH_WR_HOLD
    } pew_phase_type;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [10:0] addr;
    } pew_pins_type;

    localparam pew_pins_type PINS_RST = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 11'h000};
endpackage

// ---- src/pew_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// Contract
// - write: we, ce low with oe high
// - at most 64 bytes, gaps within window
// - further bytes only within window
// - all page bytes share A10 to A6
module pew_host #(
    parameter int POWERUP_WRITE_CYC = pew_pkg::PU_WRITE_CYC,
    parameter int PAGE_WINDOW_CYC   = pew_pkg::PAGE_WIN_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  wb_cyc,
    input  wire logic                  wb_stb,
    input  wire logic                  wb_we,
    input  wire logic [7:0]            wb_adr,
    input  wire logic [3:0]            wb_sel,
    input  wire logic [31:0]           wb_wdat,
    output logic      [31:0]           wb_rdat,
    output logic                       wb_ack,
    output pew_pkg::pew_pins_type      ee_pins,
    input  wire logic [7:0]            ee_dq_in,
    output logic      [7:0]            ee_dq_out,
    output logic                       ee_dq_oe,
    input  wire logic                  ee_rdy_in
);
    localparam logic [23:0] PU_MAX  = 24'(POWERUP_WRITE_CYC);
    localparam logic [23:0] PU_RD   = 24'(pew_pkg::PU_READ_CYC);
    localparam logic [23:0] WIN_MAX = 24'(PAGE_WINDOW_CYC);

    typedef struct packed {
        pew_pkg::pew_phase_type ph;
        pew_pkg::pew_pins_type  pins;
        logic [7:0]             dq_out;
        logic                   dq_oe;
        logic [7:0]             cnt;
        logic [23:0]            pu_cnt;
        logic [23:0]            gap;
        logic [10:0]            addr;
        logic [7:0]             wdata;
        logic [7:0]             rdata;
        logic [7:0]             dq_s1;
        logic [7:0]             dq_s2;
        logic                   rdy_s1;
        logic                   rdy_s2;
        logic                   last_bit7;
        logic                   page_open;
        logic [4:0]             page_base;
        logic [6:0]             page_cnt;
        logic                   prog;
        logic                   poll;
        logic                   have_prev;
        logic                   prev_dq6;
        logic                   done;
        logic                   err;
        logic                   dq5;
        logic                   ack;
        logic [31:0]            rdat;
    } pew_state_type;

    pew_state_type s_r;
    pew_state_type s_nxt;
    logic          rd_ok;
    logic          wr_ok;
    logic          go_rd;
    logic          go_wr;
    logic          go_poll;
    logic          page_fit;

    function automatic logic [4:0] page_of(input logic [10:0] a);
        page_of = a[pew_pkg::PAGE_MSB:pew_pkg::PAGE_LSB];
    endfunction

    assign rd_ok    = s_r.pu_cnt >= PU_RD;
    assign wr_ok    = s_r.pu_cnt == PU_MAX;
    assign page_fit = !s_r.page_open
                   || (page_of(s_r.addr) == s_r.page_base
                       && s_r.page_cnt < 7'(pew_pkg::PAGE_BYTES)
                       && s_r.gap + 24'(pew_pkg::WR_LAT_CYC) < WIN_MAX);

    always_comb begin
        s_nxt        = s_r;
        go_rd        = 1'b0;
        go_wr        = 1'b0;
        go_poll      = 1'b0;
        s_nxt.dq_s1  = ee_dq_in;
        s_nxt.dq_s2  = s_r.dq_s1;
        s_nxt.rdy_s1 = ee_rdy_in;
        s_nxt.rdy_s2 = s_r.rdy_s1;
        s_nxt.ack    = wb_cyc && wb_stb && !s_r.ack;
        s_nxt.rdat   = 32'h0000_0000;
        if (s_r.pu_cnt != PU_MAX) begin
            s_nxt.pu_cnt = s_r.pu_cnt + 24'h000001;
        end
        if (s_r.cnt != 8'h00) begin
            s_nxt.cnt = s_r.cnt - 8'h01;
        end
        // gap frozen while a byte is on the bus
        if (s_r.page_open && s_r.ph < pew_pkg::PH_WR_SETUP) begin
            if (s_r.gap >= WIN_MAX) begin
                s_nxt.page_open = 1'b0;
                s_nxt.prog      = 1'b1;
            end else begin
                s_nxt.gap = s_r.gap + 24'h000001;
            end
        end
        if (s_nxt.ack && wb_we && wb_sel[0]) begin
            case (wb_adr)
                pew_pkg::REG_CMD: begin
                    go_rd   = wb_wdat[pew_pkg::CMD_READ_BIT];
                    go_wr   = wb_wdat[pew_pkg::CMD_WRITE_BIT];
                    go_poll = wb_wdat[pew_pkg::CMD_POLL_BIT];
                end
                pew_pkg::REG_ADDR: begin
                    s_nxt.addr = wb_wdat[10:0];
                end
                pew_pkg::REG_WDATA: begin
                    s_nxt.wdata = wb_wdat[7:0];
                end
                pew_pkg::REG_STATUS: begin
                    if (wb_wdat[pew_pkg::ST_ERR]) begin
                        s_nxt.err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (s_nxt.ack && !wb_we) begin
            case (wb_adr)
                pew_pkg::REG_ADDR:  s_nxt.rdat[10:0] = s_r.addr;
                pew_pkg::REG_WDATA: s_nxt.rdat[7:0]  = s_r.wdata;
                pew_pkg::REG_RDATA: s_nxt.rdat[7:0]  = s_r.rdata;
                pew_pkg::REG_STATUS: begin
                    s_nxt.rdat[pew_pkg::ST_BUSY]      = s_r.ph != pew_pkg::PH_IDLE;
                    s_nxt.rdat[pew_pkg::ST_PAGE_OPEN] = s_r.page_open;
                    s_nxt.rdat[pew_pkg::ST_ERR]       = s_r.err;
                    s_nxt.rdat[pew_pkg::ST_WR_OK]     = wr_ok;
                    s_nxt.rdat[pew_pkg::ST_RD_OK]     = rd_ok;
                    s_nxt.rdat[pew_pkg::ST_DONE]      = s_r.done;
                    s_nxt.rdat[pew_pkg::ST_RDY]       = s_r.rdy_s2;
                    s_nxt.rdat[pew_pkg::ST_DQ5]       = s_r.dq5;
                    s_nxt.rdat[pew_pkg::ST_PROG]      = s_r.prog;
                    s_nxt.rdat[pew_pkg::ST_POLL]      = s_r.poll;
                end
                default: begin
                end
            endcase
        end
        case (s_r.ph)
            pew_pkg::PH_IDLE: begin
                if (go_wr) begin
                    if (wr_ok && !s_r.prog && !s_r.poll && page_fit) begin
                        if (!s_r.page_open) begin
                            s_nxt.page_base = page_of(s_r.addr);
                            s_nxt.page_cnt  = 7'h01;
                        end else begin
                            s_nxt.page_cnt = s_r.page_cnt + 7'h01;
                        end
                        s_nxt.page_open  = 1'b1;
                        s_nxt.gap        = 24'h000000;
                        s_nxt.done       = 1'b0;
                        s_nxt.last_bit7  = s_r.wdata[7];
                        s_nxt.dq_out     = s_r.wdata;
                        s_nxt.pins.addr  = s_r.addr;
                        s_nxt.pins.ce_n  = 1'b0;
                        s_nxt.cnt        = 8'(pew_pkg::SETUP_CYC);
                        s_nxt.ph         = pew_pkg::PH_WR_SETUP;
                    end else begin
                        s_nxt.err = 1'b1;
                    end
                end else if ((go_rd && rd_ok) || s_r.poll
                             || (go_poll && rd_ok && (s_r.prog || s_r.page_open))) begin
                    if (go_poll) begin
                        s_nxt.poll      = 1'b1;
                        s_nxt.have_prev = 1'b0;
                        s_nxt.done      = 1'b0;
                    end
                    s_nxt.pins.addr = s_r.addr;
                    s_nxt.pins.ce_n = 1'b0;
                    s_nxt.cnt       = 8'(pew_pkg::SETUP_CYC);
                    s_nxt.ph        = pew_pkg::PH_RD_SETUP;
                end
            end
            pew_pkg::PH_RD_SETUP: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.pins.oe_n = 1'b0;
                    s_nxt.cnt       = 8'(pew_pkg::ACCESS_CYC);
                    s_nxt.ph        = pew_pkg::PH_RD_WAIT;
                end
            end
            pew_pkg::PH_RD_WAIT: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.rdata     = s_r.dq_s2;
                    s_nxt.dq5       = s_r.dq_s2[5];
                    s_nxt.prev_dq6  = s_r.dq_s2[6];
                    s_nxt.have_prev = s_r.poll;
                    // finished once toggling stops and bit 7 is true again
                    if (s_r.poll && s_r.have_prev && !s_r.page_open
                        && s_r.dq_s2[6] == s_r.prev_dq6
                        && s_r.dq_s2[7] == s_r.last_bit7) begin
                        s_nxt.poll = 1'b0;
                        s_nxt.prog = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                    s_nxt.pins.oe_n = 1'b1;
                    s_nxt.pins.ce_n = 1'b1;
                    s_nxt.cnt       = 8'(pew_pkg::HOLD_CYC);
                    s_nxt.ph        = pew_pkg::PH_RD_END;
                end
            end
            pew_pkg::PH_RD_END: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.ph = pew_pkg::PH_IDLE;
                end
            end
            pew_pkg::PH_WR_SETUP: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.pins.we_n = 1'b0;
                    s_nxt.dq_oe     = 1'b1;
                    s_nxt.cnt       = 8'(pew_pkg::WE_CYC);
                    s_nxt.ph        = pew_pkg::PH_WR_PULSE;
                end
            end
            pew_pkg::PH_WR_PULSE: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.pins.we_n = 1'b1;
                    s_nxt.cnt       = 8'(pew_pkg::HOLD_CYC);
                    s_nxt.ph        = pew_pkg::PH_WR_HOLD;
                end
            end
            pew_pkg::PH_WR_HOLD: begin
                if (s_r.cnt == 8'h00) begin
                    s_nxt.pins.ce_n = 1'b1;
                    s_nxt.dq_oe     = 1'b0;
                    s_nxt.gap       = 24'h000000;
                    s_nxt.ph        = pew_pkg::PH_IDLE;
                end
            end
            default: begin
                s_nxt.ph = pew_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r      <= '0;
            s_r.ph   <= pew_pkg::PH_IDLE;
            s_r.pins <= pew_pkg::PINS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_rdat   = s_r.rdat;
    assign wb_ack    = s_r.ack;
    assign ee_pins   = s_r.pins;
    assign ee_dq_out = s_r.dq_out;
    assign ee_dq_oe  = s_r.dq_oe;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_we_low;
        $fell(ee_pins.we_n) ##0 (!ee_pins.we_n)[*3];
    endsequence
    sequence s_expire;
        s_r.page_open && s_r.ph < pew_pkg::PH_WR_SETUP && s_r.gap >= WIN_MAX;
    endsequence

    property p_wr_inhibit;
        !wr_ok |-> ee_pins.we_n;
    endproperty
    a_wr_inhibit: assert property (p_wr_inhibit) else $error("write before powerup delay");
    property p_rd_delay;
        !rd_ok |-> ee_pins.oe_n;
    endproperty
    a_rd_delay: assert property (p_rd_delay) else $error("read before powerup delay");
    property p_no_glitch;
        $fell(ee_pins.we_n) |-> s_we_low;
    endproperty
    a_no_glitch: assert property (p_no_glitch) else $error("write strobe too short");
    property p_read_mode;
        !ee_pins.oe_n |-> !ee_pins.ce_n && ee_pins.we_n && !ee_dq_oe;
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("bad read pin state");
    property p_release;
        (ee_pins.ce_n || ee_pins.we_n) && $past(ee_pins.we_n) |-> !ee_dq_oe || !ee_pins.ce_n;
    endproperty
    a_release: assert property (p_release) else $error("data driven outside write");
    property p_write_mode;
        !ee_pins.we_n |-> !ee_pins.ce_n && ee_pins.oe_n && ee_dq_oe;
    endproperty
    a_write_mode: assert property (p_write_mode) else $error("bad write pin state");
    property p_steady;
        !ee_pins.ce_n && $past(!ee_pins.ce_n) |-> $stable(ee_pins.addr) && $stable(ee_dq_out);
    endproperty
    a_steady: assert property (p_steady) else $error("address or data moved");
    property p_expire;
        s_expire |=> s_r.prog && !s_r.page_open;
    endproperty
    a_expire: assert property (p_expire) else $error("window expiry missed");
    property p_page_size;
        s_r.page_cnt <= 7'(pew_pkg::PAGE_BYTES);
    endproperty
    a_page_size: assert property (p_page_size) else $error("page over 64 bytes");
    property p_same_page;
        $fell(ee_pins.we_n) |-> page_of(ee_pins.addr) == s_r.page_base;
    endproperty
    a_same_page: assert property (p_same_page) else $error("byte off page");
    property p_done;
        $rose(s_r.done) |-> !s_r.prog && !s_r.poll && $past(s_r.ph) == pew_pkg::PH_RD_WAIT;
    endproperty
    a_done: assert property (p_done) else $error("done without poll read");
    property p_prog_block;
        s_r.prog |-> ee_pins.we_n;
    endproperty
    a_prog_block: assert property (p_prog_block) else $error("write during programming");
endmodule
`default_nettype wire

// ---- test/pew_dev_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pew_dev_model #(
    parameter int PUW  = 300,
    parameter int PUR  = 250,
    parameter int WIN  = 200,
    parameter int PROG = 400
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire pew_pkg::pew_pins_type pins,
    input  wire logic [7:0]            dq_in,
    output logic      [7:0]            dq_drv,
    output logic                       dq_en,
    output logic                       busy_low
);
    logic [7:0]  mem [0:2047];
    logic [7:0]  pdat [0:63];
    logic [63:0] pval   = '0;
    logic [4:0]  page   = '0;
    logic        bad    = 1'b0;
    logic        prog   = 1'b0;
    logic        tog    = 1'b0;
    logic        lock_r = 1'b0;
    logic [10:0] a_lat  = '0;
    logic [7:0]  last   = '0;
    int          up_cnt = 0;
    int          gap    = 0;
    int          pcnt   = 0;
    realtime     t_fall = 0.0;
    wire         wr     = !pins.ce_n && !pins.we_n && pins.oe_n;
    wire         rd     = !pins.ce_n && !pins.oe_n && pins.we_n;
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 8'hFF;
        end
    end
    // supply taken as valid from reset release
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) up_cnt <= 0;
        else if (up_cnt < PUW) up_cnt <= up_cnt + 1;
    end
    always @(posedge wr) begin
        a_lat = pins.addr;
        t_fall = $realtime;
    end
    // lock starts clear and is never set, so it blocks no writes
    always @(negedge wr) begin
        if ($realtime - t_fall >= 10.0 && up_cnt >= PUW && !lock_r && !prog) begin
            if (pval == '0) page = a_lat[10:6];
            else if (a_lat[10:6] != page) bad = 1'b1;
            pdat[a_lat[5:0]] = dq_in;
            pval[a_lat[5:0]] = 1'b1;
            last = dq_in;
            gap = 0;
        end
    end
    always @(posedge core_clk) begin
        if (pval != '0 && !prog) begin
            gap = gap + 1;
            if (gap >= WIN) begin
                prog = 1'b1;
                tog = 1'b0;
                pcnt = 0;
            end
        end else if (prog) begin
            pcnt = pcnt + 1;
            if (pcnt >= PROG) begin
                for (int i = 0; i < 64; i++) begin
                    if (pval[i] && !bad) mem[{page, 6'(i)}] = pdat[i];
                end
                prog = 1'b0;
                pval = '0;
                bad = 1'b0;
            end
        end
    end
    always @(negedge rd) begin
        if (prog) tog = ~tog;
    end
    assign dq_en = rd && up_cnt >= PUR;
    assign dq_drv = prog ? {~last[7], tog, 1'b1, 5'h00} : mem[pins.addr];
    assign busy_low = prog;
endmodule
`default_nettype wire

// ---- test/tb_pew_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_pew_host;
    logic                  core_clk;
    logic                  rst_n;
    logic                  wb_cyc;
    logic                  wb_stb;
    logic                  wb_we;
    logic [7:0]            wb_adr;
    logic [3:0]            wb_sel;
    logic [31:0]           wb_wdat;
    logic [31:0]           wb_rdat;
    logic                  wb_ack;
    pew_pkg::pew_pins_type pins;
    logic [7:0]            dq_out;
    logic                  dq_oe;
    logic [7:0]            dev_drv;
    logic                  dev_en;
    logic                  busy_low;
    logic [7:0]            dq_bus;
    logic [7:0]            dq_prev = 8'h00;
    logic                  rdy;
    int                    n_errors = 0;
    int                    n_checks = 0;
    int                    cyc_cnt = 0;
    // undriven bus shows inverse of last level
    assign dq_bus = dq_oe ? dq_out : (dev_en ? dev_drv : ~dq_prev);
    assign rdy = ~busy_low;
    always @(posedge core_clk) dq_prev <= dq_bus;
    pew_host #(.POWERUP_WRITE_CYC(300), .PAGE_WINDOW_CYC(200)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat),
        .wb_rdat(wb_rdat), .wb_ack(wb_ack), .ee_pins(pins), .ee_dq_in(dq_bus),
        .ee_dq_out(dq_out), .ee_dq_oe(dq_oe), .ee_rdy_in(rdy)
    );
    pew_dev_model #(.PUW(300), .WIN(200)) u_dev (
        .core_clk(core_clk), .rst_n(rst_n), .pins(pins), .dq_in(dq_bus),
        .dq_drv(dev_drv), .dq_en(dev_en), .busy_low(busy_low)
    );
    task automatic test_done();
        if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_wdat <= d;
        @(posedge core_clk);
        while (wb_ack !== 1'b1) begin
            @(posedge core_clk);
        end
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hF, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, 4'hF, q);
    endtask
    task automatic st_bit(input int b, input logic v);
        logic [31:0] q;
        rd(pew_pkg::REG_STATUS, q);
        chk({31'h0, q[b]}, {31'h0, v});
    endtask
    task automatic wait_st(input int b, input logic v);
        logic [31:0] q;
        int          n;
        n = 0;
        rd(pew_pkg::REG_STATUS, q);
        while (q[b] !== v && n < 600) begin
            rd(pew_pkg::REG_STATUS, q);
            n++;
        end
        chk({31'h0, q[b]}, {31'h0, v});
    endtask
    task automatic err_chk(input logic v);
        st_bit(pew_pkg::ST_ERR, v);
        wr(pew_pkg::REG_STATUS, 32'h4);
    endtask
    task automatic cmd(input int b);
        wr(pew_pkg::REG_CMD, 32'(1 << b));
        wait_st(pew_pkg::ST_BUSY, 1'b0);
    endtask
    task automatic wr_byte(input logic [10:0] a, input logic [7:0] d);
        wr(pew_pkg::REG_ADDR, {21'h0, a});
        wr(pew_pkg::REG_WDATA, {24'h0, d});
        cmd(pew_pkg::CMD_WRITE_BIT);
    endtask
    task automatic rd_byte(input logic [10:0] a, input logic [7:0] e);
        logic [31:0] q;
        wr(pew_pkg::REG_ADDR, {21'h0, a});
        cmd(pew_pkg::CMD_READ_BIT);
        rd(pew_pkg::REG_RDATA, q);
        chk(q, {24'h0, e});
    endtask
    task automatic poll(input logic [10:0] a);
        wr(pew_pkg::REG_ADDR, {21'h0, a});
        wr(pew_pkg::REG_CMD, 32'h4);
        wait_st(pew_pkg::ST_POLL, 1'b0);
        st_bit(pew_pkg::ST_DONE, 1'b1);
        st_bit(pew_pkg::ST_RDY, 1'b1);
    endtask
    task automatic t_powerup();
        chk({29'h0, pins.ce_n, pins.oe_n, pins.we_n}, 32'h7);
        st_bit(pew_pkg::ST_WR_OK, 1'b0);
        wr(pew_pkg::REG_CMD, 32'h2);
        err_chk(1'b1);
        wr(pew_pkg::REG_CMD, 32'h1);
        chk({31'h0, pins.ce_n}, 32'h1);
        wait_st(pew_pkg::ST_RD_OK, 1'b1);
        wait_st(pew_pkg::ST_WR_OK, 1'b1);
    endtask
    task automatic t_page();
        logic [31:0] q;
        wr_byte(11'h040, 8'h11);
        wr_byte(11'h041, 8'h22);
        wr_byte(11'h042, 8'hA5);
        st_bit(pew_pkg::ST_PAGE_OPEN, 1'b1);
        err_chk(1'b0);
        wr_byte(11'h100, 8'hA5);
        err_chk(1'b1);
        wr(pew_pkg::REG_ADDR, 32'h42);
        wait_st(pew_pkg::ST_PROG, 1'b1);
        st_bit(pew_pkg::ST_RDY, 1'b0);
        cmd(pew_pkg::CMD_READ_BIT);
        rd(pew_pkg::REG_RDATA, q);
        chk({29'h0, q[7:5]}, 32'h1);
        st_bit(pew_pkg::ST_DQ5, 1'b1);
        cmd(pew_pkg::CMD_READ_BIT);
        rd(pew_pkg::REG_RDATA, q);
        chk({29'h0, q[7:5]}, 32'h3);
        wr_byte(11'h043, 8'h55);
        err_chk(1'b1);
        poll(11'h042);
        rd_byte(11'h040, 8'h11);
        rd_byte(11'h042, 8'hA5);
        rd_byte(11'h043, 8'hFF);
    endtask
    task automatic t_full();
        logic [31:0] q;
        for (int i = 0; i < 64; i++) begin
            wr_byte(11'h080 + 11'(i), 8'(i) ^ 8'h3C);
        end
        err_chk(1'b0);
        wr_byte(11'h080, 8'h03);
        err_chk(1'b1);
        poll(11'h0BF);
        rd_byte(11'h080, 8'h3C);
        rd_byte(11'h0BF, 8'h03);
        rd(8'hFC, q);
        chk(q, 32'h0);
        wb(1'b1, pew_pkg::REG_ADDR, 32'h123, 4'h0, q);
        rd(pew_pkg::REG_ADDR, q);
        chk(q, 32'hBF);
    endtask
    always @(posedge core_clk) begin
        if (dq_oe === 1'b1 && dev_en === 1'b1) chk(32'h1, 32'h0);
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        rst_n = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_wdat = 32'h0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_powerup();
        t_page();
        t_full();
        test_done();
    end
endmodule
`default_nettype wire
